// >>> rtl/sfm_ctrl.sv
// mode and power control of a quad serial flash
// ***********************************************************************
// Functional notes
// - continuous read is entered only with quad enabled and mode A5h.
// - in continuous read a mode byte whose top nibble is not A exits.
// - mode byte 00h ends continuous read after the current read.
// - all ones on four lines for 8 or 10 clocks forces read exit.
// - instruction 38h with quad enabled switches to four line input.
// - instruction FFh returns to single line instruction input.
// - quad enable one permits 38h, EBh and mode A5h, zero blocks them.
// - instruction B9h enters deep power-down.
// - instruction ABh leaves deep power-down.
// - instruction 05h returns status with busy in bit 0.
// ***********************************************************************
`timescale 1ns/1ps
module sfm_ctrl
   import sfm_pkg::*;
#(
   parameter int REL_CYC = SFM_REL_CYC
)
(
   // clock and reset
   input  wire logic       core_clk,
   input  wire logic       reset_n,
   // flash pins
   input  wire logic       pin_cs_n,
   input  wire logic       pin_sck,
   input  wire logic [3:0] pin_io_i,
   output logic [3:0]      pin_io_o,
   output logic [3:0]      pin_io_oe,
   // device internal state
   input  wire logic       quad_enable_bit,
   input  wire logic       four_byte_addr,
   input  wire logic       write_in_progress_flag,
   input  wire logic [7:0] status_low,
   // mode outputs
   output logic            qpi_mode,
   output logic            cont_read,
   output logic            power_down,
   output logic            release_busy,
   output logic            hold_reset_en
);
   sfm_pin_if pins ();

   sfm_state_t st_q;
   logic [7:0] sh_q;
   logic [3:0] cnt_q;
   logic       qpi_q;
   logic       cr_q;
   logic       dpd_q;
   logic       cr_term_q;
   logic [3:0] ones_q;
   logic       ones_bad_q;
   logic       dpd_pend_q;
   logic [7:0] cmd_q;
   logic [7:0] stat_q;
   logic [15:0] rel_q;
   logic [3:0] io_o_q;
   logic [3:0] io_oe_q;
   logic       quad_ok;
   logic [3:0] bits_per;
   logic [7:0] sh_n;
   logic [3:0] addr_clk;
   logic       byte_done;
   logic [3:0] ones_lim;

   sfm_pin_sync u_sync
   (
      .core_clk (core_clk),
      .reset_n  (reset_n),
      .pin_cs_n (pin_cs_n),
      .pin_sck  (pin_sck),
      .pin_io   (pin_io_i),
      .pins     (pins)
   );

   // 38h, EBh and mode A5h are refused while the enable bit is clear
   assign quad_ok  = quad_enable_bit;
   assign addr_clk = four_byte_addr ? 4'(SFM_ADDR_CLK_4B)
                                    : 4'(SFM_ADDR_CLK_3B);
   assign ones_lim = four_byte_addr ? 4'(SFM_EXIT_CLK_4B)
                                    : 4'(SFM_EXIT_CLK_3B);
   // one line in command phase unless qpi; quad elsewhere
   assign bits_per = (st_q == SFM_ST_CMD && !qpi_q) ? 4'h1 : 4'h4;
   assign sh_n     = (bits_per == 4'h1) ? {sh_q[6:0], pins.io[0]}
                                        : {sh_q[3:0], pins.io};
   assign byte_done = (bits_per == 4'h1) ? (cnt_q == 4'h7)
                                         : (cnt_q == 4'h1);

   // ***********************************************************************
   // frame sequencer
   // ***********************************************************************
   // shifts the serial frame and decodes at byte boundaries
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         st_q      <= SFM_ST_IDLE;
         sh_q      <= 8'h00;
         cnt_q     <= 4'h0;
         qpi_q     <= 1'b0;
         cr_q      <= 1'b0;
         dpd_q     <= 1'b0;
         cr_term_q <= 1'b0;
         cmd_q     <= 8'h00;
         ones_q    <= 4'h0;
         ones_bad_q <= 1'b0;
         dpd_pend_q <= 1'b0;
      end
      else if (pins.cs_n)
      begin
         // frame end: pending terminate takes effect
         if (cr_term_q)
            cr_q <= 1'b0;
         cr_term_q <= 1'b0;
         cnt_q     <= 4'h0;
         ones_q    <= 4'h0;
         ones_bad_q <= 1'b0;
         // power-down only after deselect, never inside a frame
         if (dpd_pend_q)
            dpd_q <= 1'b1;
         dpd_pend_q <= 1'b0;
         // continuous read skips the instruction byte
         st_q <= (cr_q && !cr_term_q && !dpd_q) ? SFM_ST_ADDR
                                                : SFM_ST_CMD;
      end
      else if (pins.sck_rise)
      begin
         sh_q  <= sh_n;
         cnt_q <= cnt_q + 4'h1;
         case (st_q)
            SFM_ST_CMD:
            begin
               if (byte_done)
               begin
                  cnt_q <= 4'h0;
                  cmd_q <= sh_n;
                  st_q  <= SFM_ST_SKIP;
                  if (dpd_q)
                  begin
                     // only release is honoured in power-down
                     if (sh_n == SFM_CMD_DPD_REL)
                        dpd_q <= 1'b0;
                  end
                  else if (sh_n == SFM_CMD_DPD_ENTER)
                     dpd_pend_q <= 1'b1;
                  else if (sh_n == SFM_CMD_QPI_ENTER && quad_ok)
                     qpi_q <= 1'b1;
                  else if (sh_n == SFM_CMD_QPI_EXIT)
                     qpi_q <= 1'b0;
                  else if (sh_n == SFM_CMD_RD_STATUS)
                     st_q  <= SFM_ST_DATA;
                  else if (sh_n == SFM_CMD_QREAD && quad_ok)
                     st_q  <= SFM_ST_ADDR;
               end
            end
            SFM_ST_ADDR:
            begin
               if (cnt_q + 4'h1 == addr_clk && st_q == SFM_ST_ADDR)
               begin
                  cnt_q <= 4'h0;
                  st_q  <= SFM_ST_MODE;
               end
            end
            SFM_ST_MODE:
            begin
               if (byte_done)
               begin
                  cnt_q <= 4'h0;
                  st_q  <= SFM_ST_DUMMY;
                  if (sh_n == SFM_MODE_ENTER && quad_ok)
                     cr_q <= 1'b1;
                  else if (sh_n == SFM_MODE_TERM)
                     cr_term_q <= 1'b1;
                  else if (sh_n[7:4] != SFM_MODE_KEEP_HI)
                     cr_q <= 1'b0;
               end
            end
            SFM_ST_DUMMY:
            begin
               if (cnt_q + 4'h1 == 4'(SFM_DUMMY_CLK))
               begin
                  cnt_q <= 4'h0;
                  st_q  <= SFM_ST_DATA;
               end
            end
            SFM_ST_DATA:
               cnt_q <= 4'h0;
            SFM_ST_SKIP:
               cnt_q <= 4'h0;
            default:
               st_q <= SFM_ST_SKIP;
         endcase
         // forced exit: ones on all lines from the first clock of a
         // continuous frame; an unknown line also breaks the run;
         // kept after the case so its state wins over the sequencer
         if (cr_q && !ones_bad_q && pins.io == SFM_NIB_ONES)
         begin
            ones_q <= ones_q + 4'h1;
            if (ones_q + 4'h1 == ones_lim)
            begin
               cr_q <= 1'b0;
               st_q <= SFM_ST_SKIP;
            end
         end
         else
            ones_bad_q <= 1'b1;
      end
   end

   // ***********************************************************************
   // status output
   // ***********************************************************************
   // status shifts out on falling edges; busy lives in bit 0
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         stat_q  <= 8'h00;
         io_o_q  <= 4'h0;
         io_oe_q <= 4'h0;
      end
      else if (pins.cs_n || st_q != SFM_ST_DATA || cmd_q != SFM_CMD_RD_STATUS)
      begin
         io_oe_q <= 4'h0;
         stat_q  <= {status_low[7:1], write_in_progress_flag};
      end
      else if (pins.sck_fall)
      begin
         if (qpi_q)
         begin
            io_o_q  <= stat_q[7:4];
            io_oe_q <= 4'hF;
            stat_q  <= {stat_q[3:0], stat_q[7:4]};
         end
         else
         begin
            io_o_q  <= {2'b00, stat_q[7], 1'b0};
            io_oe_q <= 4'h2;
            stat_q  <= {stat_q[6:0], stat_q[7]};
         end
      end
   end

   // ***********************************************************************
   // release delay
   // ***********************************************************************
   // host owns the wait; this only reports it for visibility
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
         rel_q <= 16'h0000;
      else if (dpd_q)
         rel_q <= 16'(REL_CYC);
      else if (rel_q != 16'h0000)
         rel_q <= rel_q - 16'h0001;
   end

   // registered mode outputs
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         qpi_mode      <= 1'b0;
         cont_read     <= 1'b0;
         power_down    <= 1'b0;
         release_busy  <= 1'b0;
         hold_reset_en <= 1'b1;
         pin_io_o      <= 4'h0;
         pin_io_oe     <= 4'h0;
      end
      else
      begin
         qpi_mode      <= qpi_q;
         cont_read     <= cr_q;
         power_down    <= dpd_q;
         release_busy  <= (rel_q != 16'h0000) && !dpd_q;  // after release
         hold_reset_en <= 1'b1;        // fixed on, no disable
         pin_io_o      <= io_o_q;
         pin_io_oe     <= io_oe_q;
      end
   end
endmodule : sfm_ctrl

// >>> rtl/sfm_pkg.sv
// package of constants for the serial flash mode and power controller
package sfm_pkg;
   // instruction codes
   localparam logic [7:0] SFM_CMD_QPI_ENTER = 8'h38;
   localparam logic [7:0] SFM_CMD_QPI_EXIT  = 8'hFF;
   localparam logic [7:0] SFM_CMD_DPD_ENTER = 8'hB9;
   localparam logic [7:0] SFM_CMD_DPD_REL   = 8'hAB;
   localparam logic [7:0] SFM_CMD_RD_STATUS = 8'h05;
   localparam logic [7:0] SFM_CMD_QREAD     = 8'hEB;
   // mode byte values
   localparam logic [7:0] SFM_MODE_ENTER    = 8'hA5;
   localparam logic [3:0] SFM_MODE_KEEP_HI  = 4'hA;
   localparam logic [7:0] SFM_MODE_TERM     = 8'h00;
   localparam logic [3:0] SFM_NIB_ONES      = 4'hF;
   // forced exit clock counts
   localparam int         SFM_EXIT_CLK_3B   = 8;
   localparam int         SFM_EXIT_CLK_4B   = 10;
   // status bit position of write in progress
   localparam int         SFM_BUSY_BIT      = 0;
   // address and dummy clock counts
   localparam int         SFM_ADDR_CLK_3B   = 6;
   localparam int         SFM_ADDR_CLK_4B   = 8;
   localparam int         SFM_DUMMY_CLK     = 4;
   // release delay: (count+1) * unit
   localparam int         SFM_REL_COUNT     = 5'h13;
   localparam int         SFM_REL_UNIT_NS   = 1000;
   localparam int         SFM_CLK_NS        = 25;
   localparam int         SFM_REL_CYC       =
      ((SFM_REL_COUNT + 1) * SFM_REL_UNIT_NS) / SFM_CLK_NS;
   // bus states
   typedef enum logic [2:0]
   {
      SFM_ST_IDLE  = 3'h0,
      SFM_ST_CMD   = 3'h1,
      SFM_ST_ADDR  = 3'h3,
      SFM_ST_MODE  = 3'h2,
      SFM_ST_DUMMY = 3'h6,
      SFM_ST_DATA  = 3'h7,
      SFM_ST_SKIP  = 3'h5
   } sfm_state_t;
endpackage : sfm_pkg

// >>> rtl/sfm_pin_if.sv
// interface carrying synchronised pin samples and edge events
`timescale 1ns/1ps
interface sfm_pin_if;
   logic       cs_n;
   logic       sck_rise;
   logic       sck_fall;
   logic [3:0] io;
   modport src (output cs_n, output sck_rise, output sck_fall, output io);
   modport dst (input cs_n, input sck_rise, input sck_fall, input io);
endinterface : sfm_pin_if

// >>> rtl/sfm_pin_sync.sv
// two flop synchroniser and clock edge finder for the flash pins
`timescale 1ns/1ps
module sfm_pin_sync
(
   // clock and reset
   input  wire logic core_clk,
   input  wire logic reset_n,
   // raw pins
   input  wire logic       pin_cs_n,
   input  wire logic       pin_sck,
   input  wire logic [3:0] pin_io,
   // synchronised side
   sfm_pin_if.src          pins
);
   logic [5:0] meta_q;
   logic [5:0] sync_q;
   logic       sck_old_q;

   // two flops; first stage feeds only the second
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         meta_q    <= 6'h01;
         sync_q    <= 6'h01;
         sck_old_q <= 1'b0;
      end
      else
      begin
         meta_q    <= {pin_io, pin_sck, pin_cs_n};
         sync_q    <= meta_q;
         sck_old_q <= sync_q[1];
      end
   end

   // edge events from second stage only
   assign pins.cs_n     = sync_q[0];
   assign pins.io       = sync_q[5:2];
   assign pins.sck_rise = sync_q[1] & ~sck_old_q;
   assign pins.sck_fall = ~sync_q[1] & sck_old_q;
endmodule : sfm_pin_sync

// >>> tb/sfm_ctrl_properties.sv
// checker of mode and power behaviour at the controller ports
`timescale 1ns/1ps
module sfm_ctrl_properties
#(
   parameter int REL_CYC = 20
)
(
   // clock and reset
   input wire logic       core_clk,
   input wire logic       reset_n,
   // pins and device state
   input wire logic       pin_cs_n,
   input wire logic [3:0] pin_io_oe,
   input wire logic       quad_enable_bit,
   // mode outputs
   input wire logic       qpi_mode,
   input wire logic       cont_read,
   input wire logic       power_down,
   input wire logic       release_busy,
   input wire logic       hold_reset_en
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   // busy length counter, wide enough for the full default delay
   logic [15:0] busy_cnt_q;
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
         busy_cnt_q <= 16'h0000;
      else
         busy_cnt_q <= release_busy ? busy_cnt_q + 16'h0001 : 16'h0000;
   end
   // *****
   // assertions
   // *****
   a_hold_always_on: assert property (hold_reset_en)
      else $error("hold and reset function disabled");
   a_busy_exact_len: assert property (
      $fell(release_busy) |-> busy_cnt_q == 16'(REL_CYC))
      else $error("release busy length wrong");
   a_release_sets_busy: assert property (
      $fell(power_down) |-> ##[0:2] release_busy)
      else $error("no release busy after power-down exit");
   a_pd_holds_modes: assert property (
      power_down && $past(power_down) |-> $stable(qpi_mode) && !cont_read)
      else $error("mode changed in power-down");
   a_pd_no_drive: assert property (
      power_down |-> pin_io_oe == 4'h0)
      else $error("lines driven in power-down");
   a_pd_after_frame: assert property (
      $rose(power_down) |-> pin_cs_n)
      else $error("power-down entered inside a frame");
   a_qpi_needs_enable: assert property (
      $rose(qpi_mode) |-> quad_enable_bit)
      else $error("four line mode without quad enable");
   a_cont_needs_enable: assert property (
      $rose(cont_read) |-> quad_enable_bit && !pin_cs_n)
      else $error("continuous read entered wrongly");
   a_enable_blocks_quad: assert property (
      !quad_enable_bit && !qpi_mode |=> !qpi_mode)
      else $error("quad mode entered with quad enable low");
   a_idle_no_drive: assert property (
      pin_cs_n [*6] |-> pin_io_oe == 4'h0)
      else $error("lines driven while deselected");
   c_cont_entry: cover property ($rose(cont_read));
   c_pd_release: cover property ($fell(power_down));
   c_qpi_entry: cover property ($rose(qpi_mode));
endmodule : sfm_ctrl_properties

bind sfm_ctrl sfm_ctrl_properties #(.REL_CYC(REL_CYC)) u_sfm_ctrl_properties (
   .core_clk(core_clk), .reset_n(reset_n), .pin_cs_n(pin_cs_n),
   .pin_io_oe(pin_io_oe), .quad_enable_bit(quad_enable_bit),
   .qpi_mode(qpi_mode), .cont_read(cont_read), .power_down(power_down),
   .release_busy(release_busy), .hold_reset_en(hold_reset_en));

// >>> tb/sfm_host_model.sv
// host controller model driving the quad serial bus
`timescale 1ns/1ps
module sfm_host_model
(
   // alignment clock
   input wire logic       core_clk,
   // bus pins
   output logic           cs_n,
   output logic           sck,
   output logic [3:0]     io,
   output logic [3:0]     io_oe,
   input wire logic [3:0] io_in
);
   // bus idle: deselected, clock still, lines released
   initial
   begin
      cs_n = 1'b1;
      sck = 1'b0;
      io = 4'h0;
      io_oe = 4'h0;
   end
   // frame starts on a falling core edge so all steps stay off rising
   task automatic open_frame();
   begin
      @(negedge core_clk);
      cs_n = 1'b0;
      #100;
   end
   endtask : open_frame
   // gap after a frame is far above the three cycle minimum
   task automatic close_frame();
   begin
      io_oe = 4'h0;
      #100;
      cs_n = 1'b1;
      #200;
   end
   endtask : close_frame
   // n clocks with v on the enabled lines, device samples at rise
   task automatic clocks(input logic [3:0] v, input logic [3:0] oe,
                         input int n);
   begin
      for (int i = 0; i < n; i++)
      begin
         io = v;
         io_oe = oe;
         #100;
         sck = 1'b1;
         #100;
         sck = 1'b0;
      end
   end
   endtask : clocks
   // instruction msb first, one line or nibbles on four
   task automatic send_cmd(input logic [7:0] b, input logic quad);
   begin
      if (quad)
      begin
         clocks(b[7:4], 4'hF, 1);
         clocks(b[3:0], 4'hF, 1);
      end
      else
         for (int i = 7; i >= 0; i--)
            clocks({3'b000, b[i]}, 4'h1, 1);
   end
   endtask : send_cmd
   // single line read on line one, sampled late in the high phase
   task automatic read_byte(output logic [7:0] v);
   begin
      io_oe = 4'h0;
      for (int i = 7; i >= 0; i--)
      begin
         #100;
         sck = 1'b1;
         #99;
         v[i] = io_in[1];
         #1;
         sck = 1'b0;
      end
   end
   endtask : read_byte
endmodule : sfm_host_model

// >>> tb/test_serial_flash_mode_power_control.sv
// self-checking bench of the mode and power controller
`timescale 1ns/1ps
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin \
   num_errors++; $display("ERROR t=%0t got %h exp %h", $time, got, exp); \
   end end
module test_serial_flash_mode_power_control;
   import sfm_pkg::*;
   localparam int REL_CYC = 20;
   logic       core_clk, reset_n, cs_n, sck;
   logic       flip = 1'b0;
   logic       quad_enable_bit, four_byte_addr, write_in_progress_flag;
   logic       qpi_mode, cont_read, power_down, release_busy, hold_reset_en;
   logic [7:0] status_low, rd_v;
   logic [3:0] pin_io_i, pin_io_o, pin_io_oe, host_io, host_oe, idle;
   int         num_errors = 0;
   int         compares = 0;
   // released lines: pull-ups on two, a toggling pattern on the rest
   assign idle = {2'b11, flip, ~flip};
   assign pin_io_i = (host_io & host_oe) | (pin_io_o & pin_io_oe & ~host_oe)
                   | (idle & ~host_oe & ~pin_io_oe);
   sfm_ctrl #(.REL_CYC(REL_CYC)) u_sfm_ctrl (.core_clk(core_clk),
      .reset_n(reset_n), .pin_cs_n(cs_n), .pin_sck(sck),
      .pin_io_i(pin_io_i), .pin_io_o(pin_io_o), .pin_io_oe(pin_io_oe),
      .quad_enable_bit(quad_enable_bit), .four_byte_addr(four_byte_addr),
      .write_in_progress_flag(write_in_progress_flag),
      .status_low(status_low), .qpi_mode(qpi_mode), .cont_read(cont_read),
      .power_down(power_down), .release_busy(release_busy),
      .hold_reset_en(hold_reset_en));
   sfm_host_model u_sfm_host_model (.core_clk(core_clk), .cs_n(cs_n),
      .sck(sck), .io(host_io), .io_oe(host_oe), .io_in(pin_io_i));
   // 40 MHz core clock and the idle pattern toggle
   initial
   begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   always @(posedge core_clk) flip <= ~flip;
   // verdict and end of run
   task automatic wrap_up();
   begin
      if (num_errors == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   end
   endtask : wrap_up
   // one complete instruction frame
   task automatic cmd(input logic [7:0] b, input logic quad);
   begin
      u_sfm_host_model.open_frame();
      u_sfm_host_model.send_cmd(b, quad);
      u_sfm_host_model.close_frame();
   end
   endtask : cmd
   // quad read frame, opcode only when not in continuous read
   task automatic qread(input logic op, input logic [7:0] mode);
   begin
      u_sfm_host_model.open_frame();
      if (op)
         u_sfm_host_model.send_cmd(SFM_CMD_QREAD, 1'b0);
      u_sfm_host_model.clocks(4'h0, 4'hF,
         four_byte_addr ? SFM_ADDR_CLK_4B : SFM_ADDR_CLK_3B);
      u_sfm_host_model.clocks(mode[7:4], 4'hF, 1);
      u_sfm_host_model.clocks(mode[3:0], 4'hF, 1);
      u_sfm_host_model.clocks(4'h0, 4'h0, SFM_DUMMY_CLK + 2);
      u_sfm_host_model.close_frame();
   end
   endtask : qread
   // four line instruction mode entry, refusal and exit
   task automatic t_qpi();
   begin
      @(negedge core_clk) quad_enable_bit = 1'b0;
      cmd(SFM_CMD_QPI_ENTER, 1'b0);
      `CHK(qpi_mode, 1'b0)
      @(negedge core_clk) quad_enable_bit = 1'b1;
      cmd(SFM_CMD_QPI_ENTER, 1'b0);
      `CHK(qpi_mode, 1'b1)
      cmd(SFM_CMD_QPI_EXIT, 1'b1);
      `CHK(qpi_mode, 1'b0)
   end
   endtask : t_qpi
   // status read with busy flag in bit zero, both flag values
   task automatic t_status();
   begin
      for (int w = 0; w < 2; w++)
      begin
         @(negedge core_clk) write_in_progress_flag = w[0];
         u_sfm_host_model.open_frame();
         u_sfm_host_model.send_cmd(SFM_CMD_RD_STATUS, 1'b0);
         u_sfm_host_model.read_byte(rd_v);
         u_sfm_host_model.close_frame();
         `CHK(rd_v, {status_low[7:1], w[0]})
      end
   end
   endtask : t_status
   // continuous read entry and every exit path
   task automatic t_cont();
   begin
      @(negedge core_clk) quad_enable_bit = 1'b0;
      qread(1'b1, SFM_MODE_ENTER);
      `CHK(cont_read, 1'b0)
      @(negedge core_clk) quad_enable_bit = 1'b1;
      qread(1'b1, SFM_MODE_ENTER);
      `CHK(cont_read, 1'b1)
      qread(1'b0, SFM_MODE_TERM);
      `CHK(cont_read, 1'b0)
      qread(1'b1, SFM_MODE_ENTER);
      qread(1'b0, 8'hA0);
      `CHK(cont_read, 1'b1)
      qread(1'b0, 8'h5A);
      `CHK(cont_read, 1'b0)
      for (int f = 0; f < 2; f++)
      begin
         @(negedge core_clk) four_byte_addr = f[0];
         qread(1'b1, SFM_MODE_ENTER);
         if (f)
         begin
            // eight ones are only address clocks in four byte mode
            u_sfm_host_model.open_frame();
            u_sfm_host_model.clocks(SFM_NIB_ONES, 4'hF, SFM_EXIT_CLK_3B);
            u_sfm_host_model.close_frame();
            `CHK(cont_read, 1'b1)
         end
         u_sfm_host_model.open_frame();
         u_sfm_host_model.clocks(SFM_NIB_ONES, 4'hF,
            f ? SFM_EXIT_CLK_4B : SFM_EXIT_CLK_3B);
         u_sfm_host_model.close_frame();
         `CHK(cont_read, 1'b0)
      end
      four_byte_addr = 1'b0;
   end
   endtask : t_cont
   // deep power-down entry, ignored instruction, release and delay
   task automatic t_power();
   begin
      cmd(SFM_CMD_DPD_ENTER, 1'b0);
      `CHK(power_down, 1'b1)
      cmd(SFM_CMD_QPI_ENTER, 1'b0);
      `CHK(qpi_mode, 1'b0)
      cmd(SFM_CMD_DPD_REL, 1'b0);
      `CHK({power_down, release_busy}, 2'b01)
      repeat (REL_CYC) @(negedge core_clk);
      `CHK(release_busy, 1'b0)
   end
   endtask : t_power
   // main sequence after a 12 cycle reset
   initial
   begin
      reset_n = 1'b0;
      quad_enable_bit = 1'b0;
      four_byte_addr = 1'b0;
      write_in_progress_flag = 1'b0;
      status_low = 8'hA4;
      repeat (12) @(negedge core_clk);
      reset_n = 1'b1;
      repeat (4) @(negedge core_clk);
      `CHK({qpi_mode, cont_read, power_down, hold_reset_en}, 4'h1)
      t_qpi();
      t_status();
      t_cont();
      t_power();
      wrap_up();
   end
   // watchdog, far beyond the roughly 60 us the tests need
   initial
   begin
      #1000000;
      num_errors++;
      wrap_up();
   end
endmodule : test_serial_flash_mode_power_control
